// ===== core/ascii_link_read_framer.sv
`timescale 1ns/100ps
`default_nettype none
module ascii_link_read_framer #(
	parameter int MS_CYCLES = (ascii_link_pkg::MS_NS + ascii_link_pkg::CLK_PERIOD_NS - 1)
	                          / ascii_link_pkg::CLK_PERIOD_NS
) (
	input  wire logic                      core_clk_i,
	input  wire logic                      sys_rst_i,
	input  wire logic [4:0]                station_i,
	input  wire logic [15:0]               reply_wait_setting_i,
	input  wire logic [1:0]                line_end_selection_i,
	input  wire ascii_link_pkg::rx_char_t  rx_char_i,
	input  wire logic                      rx_valid_i,
	output logic [7:0]                     tx_data_o,
	output logic                           tx_valid_o,
	input  wire logic                      tx_ready_i,
	output logic                           rd_req_o,
	output logic [7:0]                     rd_code_o,
	input  wire logic                      rd_rsp_valid_i,
	input  wire ascii_link_pkg::read_rsp_t rd_rsp_i
);

	typedef enum logic [2:0] {
		ST_HUNT, ST_COLLECT, ST_LINE_END, ST_EVAL, ST_WAIT, ST_CHECK, ST_TX, ST_HOST_ANS
	} state_t;

	state_t                    state_ff,     nxt_state;
	logic [4:0]                cnt_ff,       nxt_cnt;
	logic [27:0]               nib_ff,       nxt_nib;
	logic [7:0]                csum_ff,      nxt_csum;
	logic [3:0]                err_ff,       nxt_err;
	logic                      reply_err_ff, nxt_reply_err;
	logic [3:0]                code_err_ff,  nxt_code_err;
	ascii_link_pkg::read_rsp_t rsp_ff,       nxt_rsp;
	logic                      rsp_got_ff,   nxt_rsp_got;
	logic [4:0]                tx_idx_ff,    nxt_tx_idx;
	logic [7:0]                tx_byte_ff,   nxt_tx_byte;
	logic [7:0]                tx_sum_ff,    nxt_tx_sum;
	logic                      nak_ff,       nxt_nak;
	logic                      bad_ff,       nxt_bad;
	logic                      req_ff,       nxt_req;
	logic [7:0]                code_ff,      nxt_code;
	logic        digit_mode, tmr_start, tmr_busy, in_sum;
	logic [15:0] tmr_ms, wait_ms, check_ms;
	logic [4:0]  req_len, le_total, body_len, tx_last, pick_idx, data_len;
	logic [7:0]  ch, rx_station, rx_code, rx_sum, pick_sum, pick_byte, sum_after, stn_byte;
	logic [3:0]  ch_err;

	ms_delay_timer #(
		.MS_CYCLES (MS_CYCLES)
	) u_timer (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.start_i    (tmr_start),
		.ms_i       (tmr_ms),
		.busy_o     (tmr_busy)
	);

	// ==========================================================
	// Field decode of the captured request, plus reply lengths from the captured response
	always_comb begin
		ch         = rx_char_i.data;
		ch_err     = ascii_link_pkg::link_err(rx_char_i);
		digit_mode = (reply_wait_setting_i == ascii_link_pkg::WAIT_DIGIT_MODE);
		req_len    = digit_mode ? ascii_link_pkg::REQ_LEN_DIGIT
		                        : ascii_link_pkg::REQ_LEN_DIGIT - 5'h01;
		le_total   = {4'h0, line_end_selection_i[ascii_link_pkg::LE_CR_BIT]}
		           + {4'h0, line_end_selection_i[ascii_link_pkg::LE_LF_BIT]};
		rx_station = digit_mode ? nib_ff[27:20] : nib_ff[23:16];
		rx_code    = digit_mode ? nib_ff[19:12] : nib_ff[15:8];
		rx_sum     = nib_ff[7:0];
		// Digit times step, else the setting itself, both in ms
		wait_ms    = digit_mode ? {12'h000, nib_ff[11:8]} * ascii_link_pkg::STEP_MS
		                        : reply_wait_setting_i;
		// Check time spreads over the allowed range by code low bits
		check_ms   = code_ff[1] ? ascii_link_pkg::CHECK_MAX_MS
		           : (code_ff[0] ? ascii_link_pkg::CHECK_MIN_MS + ascii_link_pkg::STEP_MS
		                         : ascii_link_pkg::CHECK_MIN_MS);
		data_len   = ascii_link_pkg::fmt_len(rsp_ff.fmt);
		body_len   = reply_err_ff ? ascii_link_pkg::ERR_BODY_LEN
		                          : data_len + ascii_link_pkg::READ_OVERHEAD;
		tx_last    = body_len + le_total - 5'h01;
		stn_byte   = {3'h0, station_i};
	end

	// ==========================================================
	// Reply character picker; kept apart from the FSM so the byte
	// for the next slot never feeds back into its own index
	always_comb begin
		in_sum    = (tx_idx_ff >= ascii_link_pkg::POS_STN_HI) && !reply_err_ff
		          && (tx_idx_ff <= data_len + ascii_link_pkg::POS_BODY);
		sum_after = tx_sum_ff + (in_sum ? tx_byte_ff : 8'h00);
		pick_idx  = (state_ff == ST_TX) ? tx_idx_ff + 5'h01 : 5'h00;
		pick_sum  = (state_ff == ST_TX) ? sum_after : 8'h00;
		pick_byte = ascii_link_pkg::CH_LF;
		if (pick_idx == 5'h00) begin
			pick_byte = reply_err_ff ? ascii_link_pkg::CH_NAK : ascii_link_pkg::CH_STX;
		end else if (pick_idx == ascii_link_pkg::POS_STN_HI) begin
			pick_byte = ascii_link_pkg::to_hex(stn_byte[7:4]);
		end else if (pick_idx == ascii_link_pkg::POS_STN_LO) begin
			pick_byte = ascii_link_pkg::to_hex(stn_byte[3:0]);
		end else if (pick_idx < body_len) begin
			if (reply_err_ff)
				pick_byte = ascii_link_pkg::to_hex(code_err_ff);
			else if (pick_idx < data_len + ascii_link_pkg::POS_BODY)
				pick_byte = rsp_ff.data[pick_idx - ascii_link_pkg::POS_BODY];
			else if (pick_idx == data_len + ascii_link_pkg::POS_BODY)
				pick_byte = ascii_link_pkg::CH_ETX;
			else if (pick_idx == body_len - ascii_link_pkg::SUM_CHARS)
				pick_byte = ascii_link_pkg::to_hex(pick_sum[7:4]);
			else
				pick_byte = ascii_link_pkg::to_hex(pick_sum[3:0]);
		end else if (pick_idx == body_len && line_end_selection_i[ascii_link_pkg::LE_CR_BIT]) begin
			pick_byte = ascii_link_pkg::CH_CR;
		end
	end

	// ==========================================================
	// Frame state machine
	always_comb begin
		nxt_state     = state_ff;
		nxt_cnt       = cnt_ff;
		nxt_nib       = nib_ff;
		nxt_csum      = csum_ff;
		nxt_err       = err_ff;
		nxt_reply_err = reply_err_ff;
		nxt_code_err  = code_err_ff;
		nxt_rsp       = rsp_ff;
		nxt_rsp_got   = rsp_got_ff;
		nxt_tx_idx    = tx_idx_ff;
		nxt_tx_byte   = tx_byte_ff;
		nxt_tx_sum    = tx_sum_ff;
		nxt_nak       = nak_ff;
		nxt_bad       = bad_ff;
		nxt_req       = 1'b0;
		nxt_code      = code_ff;
		tmr_start     = 1'b0;
		tmr_ms        = 16'h0000;
		// A response may land any time after the request pulse
		if (rd_rsp_valid_i && (state_ff == ST_WAIT || state_ff == ST_CHECK)) begin
			nxt_rsp     = rd_rsp_i;
			nxt_rsp_got = 1'b1;
		end
		case (state_ff)
			ST_HUNT, ST_COLLECT, ST_LINE_END, ST_HOST_ANS: begin
				// A fresh ENQ restarts a request in hunt, collect, line end and host answer, even mid-frame
				if (rx_valid_i && ch == ascii_link_pkg::CH_ENQ) begin
					nxt_state = ST_COLLECT;
					nxt_cnt   = 5'h00;
					nxt_nib   = 28'h0000000;
					nxt_csum  = 8'h00;
					nxt_err   = ch_err;
				end else if (rx_valid_i && state_ff == ST_COLLECT) begin
					nxt_cnt = cnt_ff + 5'h01;
					nxt_nib = {nib_ff[23:0], ascii_link_pkg::hex_val(ch)};
					if (cnt_ff < req_len - 5'h03)
						nxt_csum = csum_ff + ch;
					if (err_ff == ascii_link_pkg::ERR_NONE) begin
						if (ch_err != ascii_link_pkg::ERR_NONE)
							nxt_err = ch_err;
						else if (!ascii_link_pkg::is_hex(ch))
							nxt_err = ascii_link_pkg::ERR_CHAR;
					end
					if (cnt_ff == req_len - 5'h02) begin
						nxt_cnt   = 5'h00;
						nxt_state = (le_total == 5'h00) ? ST_EVAL : ST_LINE_END;
					end
				end else if (rx_valid_i && state_ff == ST_LINE_END) begin
					nxt_cnt = cnt_ff + 5'h01;
					// First expected char is CR only if CR is selected
					if (err_ff == ascii_link_pkg::ERR_NONE) begin
						if (ch_err != ascii_link_pkg::ERR_NONE)
							nxt_err = ch_err;
						else if (ch != ((cnt_ff == 5'h00
						         && line_end_selection_i[ascii_link_pkg::LE_CR_BIT])
						         ? ascii_link_pkg::CH_CR : ascii_link_pkg::CH_LF))
							nxt_err = ascii_link_pkg::ERR_PROTOCOL;
					end
					if (cnt_ff == le_total - 5'h01)
						nxt_state = ST_EVAL;
				end else if (rx_valid_i && state_ff == ST_HOST_ANS) begin
					nxt_cnt = cnt_ff + 5'h01;
					if (cnt_ff == 5'h00) begin
						nxt_nak = (ch == ascii_link_pkg::CH_NAK);
						nxt_bad = (ch != ascii_link_pkg::CH_NAK) && (ch != ascii_link_pkg::CH_ACK);
					end else if (cnt_ff == ascii_link_pkg::POS_STN_HI) begin
						nxt_bad = bad_ff || (ch != ascii_link_pkg::to_hex(stn_byte[7:4]));
					end else if (cnt_ff == ascii_link_pkg::POS_STN_LO) begin
						nxt_bad = bad_ff || (ch != ascii_link_pkg::to_hex(stn_byte[3:0]));
					end
					if (cnt_ff == ascii_link_pkg::POS_STN_LO + le_total) begin
						nxt_cnt = 5'h00;
						if (bad_ff || nxt_bad) begin
							nxt_state = ST_HOST_ANS;
						end else if (nak_ff || nxt_nak) begin
							nxt_state   = ST_TX;
							nxt_tx_idx  = 5'h00;
							nxt_tx_sum  = 8'h00;
							nxt_tx_byte = pick_byte;
						end else begin
							nxt_state = ST_HUNT;
						end
					end
				end
			end
			ST_EVAL: begin
				nxt_rsp_got = 1'b0;
				// Foreign or out-of-range station: stay silent
				if (rx_station != stn_byte || rx_station > ascii_link_pkg::STATION_MAX) begin
					nxt_state = ST_HUNT;
				end else begin
					nxt_state = ST_WAIT;
					tmr_start = 1'b1;
					tmr_ms    = wait_ms;
					if (err_ff != ascii_link_pkg::ERR_NONE) begin
						nxt_reply_err = 1'b1;
						nxt_code_err  = err_ff;
					end else if (csum_ff != rx_sum) begin
						nxt_reply_err = 1'b1;
						nxt_code_err  = ascii_link_pkg::ERR_SUM;
					end else begin
						nxt_reply_err = 1'b0;
						nxt_req       = 1'b1;
						nxt_code      = rx_code; // Served reads only, so the code holds otherwise
					end
				end
			end
			ST_WAIT: begin
				if (!tmr_busy) begin
					if (reply_err_ff) begin
						nxt_state   = ST_TX;
						nxt_tx_idx  = 5'h00;
						nxt_tx_sum  = 8'h00;
						nxt_tx_byte = pick_byte;
					end else begin
						nxt_state = ST_CHECK;
						tmr_start = 1'b1;
						tmr_ms    = check_ms;
					end
				end
			end
			ST_CHECK: begin
				// Reply holds until both the check time and the data are in
				if (!tmr_busy && rsp_got_ff) begin
					nxt_state   = ST_TX;
					nxt_tx_idx  = 5'h00;
					nxt_tx_sum  = 8'h00;
					nxt_tx_byte = pick_byte;
					if (rsp_ff.is_err) begin
						nxt_reply_err = 1'b1;
						nxt_code_err  = rsp_ff.err_code;
						nxt_tx_byte   = ascii_link_pkg::CH_NAK;
					end
				end
			end
			ST_TX: begin
				if (tx_ready_i) begin
					if (tx_idx_ff == tx_last) begin
						nxt_cnt   = 5'h00;
						nxt_state = reply_err_ff ? ST_HUNT : ST_HOST_ANS;
					end else begin
						nxt_tx_idx  = tx_idx_ff + 5'h01;
						nxt_tx_byte = pick_byte;
						nxt_tx_sum  = sum_after;
					end
				end
			end
			default: begin
				nxt_state = ST_HUNT;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			state_ff     <= ST_HUNT;
			cnt_ff       <= 5'h00;
			nib_ff       <= 28'h0000000;
			csum_ff      <= 8'h00;
			err_ff       <= ascii_link_pkg::ERR_NONE;
			reply_err_ff <= 1'b0;
			code_err_ff  <= ascii_link_pkg::ERR_NONE;
			rsp_ff       <= '0;
			rsp_got_ff   <= 1'b0;
			tx_idx_ff    <= 5'h00;
			tx_byte_ff   <= 8'h00;
			tx_sum_ff    <= 8'h00;
			nak_ff       <= 1'b0;
			bad_ff       <= 1'b0;
			req_ff       <= 1'b0;
			code_ff      <= 8'h00;
		end else begin
			state_ff     <= nxt_state;
			cnt_ff       <= nxt_cnt;
			nib_ff       <= nxt_nib;
			csum_ff      <= nxt_csum;
			err_ff       <= nxt_err;
			reply_err_ff <= nxt_reply_err;
			code_err_ff  <= nxt_code_err;
			rsp_ff       <= nxt_rsp;
			rsp_got_ff   <= nxt_rsp_got;
			tx_idx_ff    <= nxt_tx_idx;
			tx_byte_ff   <= nxt_tx_byte;
			tx_sum_ff    <= nxt_tx_sum;
			nak_ff       <= nxt_nak;
			bad_ff       <= nxt_bad;
			req_ff       <= nxt_req;
			code_ff      <= nxt_code;
		end
	end

	// ==========================================================
	// Outputs
	assign tx_valid_o = (state_ff == ST_TX);
	assign tx_data_o  = tx_byte_ff;
	assign rd_req_o   = req_ff;
	assign rd_code_o  = code_ff;
endmodule : ascii_link_read_framer
`default_nettype wire

// ===== core/ascii_link_pkg.sv
package ascii_link_pkg;

	// ==========================================================
	// Control characters
	localparam logic [7:0] CH_STX = 8'h02;
	localparam logic [7:0] CH_ETX = 8'h03;
	localparam logic [7:0] CH_ENQ = 8'h05;
	localparam logic [7:0] CH_ACK = 8'h06;
	localparam logic [7:0] CH_LF  = 8'h0a;
	localparam logic [7:0] CH_CR  = 8'h0d;
	localparam logic [7:0] CH_NAK = 8'h15;

	// ==========================================================
	// Error codes sent in a negative reply; NONE is the normal code
	localparam logic [3:0] ERR_PARITY   = 4'h1;
	localparam logic [3:0] ERR_SUM      = 4'h2;
	localparam logic [3:0] ERR_PROTOCOL = 4'h3;
	localparam logic [3:0] ERR_FRAMING  = 4'h4;
	localparam logic [3:0] ERR_OVERRUN  = 4'h5;
	localparam logic [3:0] ERR_CHAR     = 4'h7;
	localparam logic [3:0] ERR_NONE     = 4'hf;

	// ==========================================================
	// Timing
	localparam int          CLK_PERIOD_NS   = 100;
	localparam int          MS_NS           = 1000000;
	localparam logic [15:0] STEP_MS         = 16'h000a;
	localparam logic [15:0] CHECK_MIN_MS    = 16'h000a;
	localparam logic [15:0] CHECK_MAX_MS    = 16'h001e;
	localparam logic [15:0] WAIT_DIGIT_MODE = 16'h270f;

	// ==========================================================
	// Frame layout (positions counted from 0 at the control char)
	localparam logic [4:0] REQ_LEN_DIGIT = 5'h08;
	localparam logic [4:0] POS_STN_HI    = 5'h01;
	localparam logic [4:0] POS_STN_LO    = 5'h02;
	localparam logic [4:0] POS_BODY      = 5'h03;
	localparam logic [4:0] ERR_BODY_LEN  = 5'h04;
	localparam logic [4:0] READ_OVERHEAD = 5'h06;
	localparam logic [4:0] SUM_CHARS     = 5'h02;
	localparam logic [4:0] LEN_FOUR      = 5'h04;
	localparam logic [4:0] LEN_TWO       = 5'h02;
	localparam logic [4:0] LEN_SIX       = 5'h06;
	localparam logic [4:0] LEN_MODEL     = 5'h14;
	localparam logic [7:0] STATION_MAX   = 8'h1f;
	localparam int         LE_CR_BIT     = 0;
	localparam int         LE_LF_BIT     = 1;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {FMT_FOUR, FMT_TWO, FMT_SIX, FMT_MODEL} read_fmt_t;

	typedef struct packed {
		logic [7:0] data;
		logic       parity_err;
		logic       framing_err;
		logic       overrun_err;
	} rx_char_t;

	typedef struct packed {
		read_fmt_t       fmt;
		logic            is_err;
		logic [3:0]      err_code;
		logic [19:0][7:0] data;
	} read_rsp_t;

	// ==========================================================
	// Character helpers
	function automatic logic is_hex(input logic [7:0] c);
		return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
	endfunction : is_hex

	function automatic logic [3:0] hex_val(input logic [7:0] c);
		logic [7:0] v;
		v = (c <= 8'h39) ? c - 8'h30 : c - 8'h37;
		return v[3:0];
	endfunction : hex_val

	function automatic logic [7:0] to_hex(input logic [3:0] n);
		return (n <= 4'h9) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
	endfunction : to_hex

	function automatic logic [4:0] fmt_len(input read_fmt_t f);
		case (f)
			FMT_TWO:   return LEN_TWO;
			FMT_SIX:   return LEN_SIX;
			FMT_MODEL: return LEN_MODEL;
			default:   return LEN_FOUR;
		endcase
	endfunction : fmt_len

	function automatic logic [3:0] link_err(input rx_char_t r);
		if (r.parity_err)
			return ERR_PARITY;
		if (r.framing_err)
			return ERR_FRAMING;
		if (r.overrun_err)
			return ERR_OVERRUN;
		return ERR_NONE;
	endfunction : link_err

endpackage : ascii_link_pkg

// ===== core/ms_delay_timer.sv
`timescale 1ns/100ps
`default_nettype none

module ms_delay_timer #(
	parameter int MS_CYCLES = 10000
) (
	input  wire logic        core_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        start_i,
	input  wire logic [15:0] ms_i,
	output logic             busy_o
);

	localparam logic [15:0] PRE_TOP = 16'(MS_CYCLES - 1);

	logic        busy_ff,    nxt_busy;
	logic [15:0] ms_left_ff, nxt_ms_left;
	logic [15:0] pre_ff,     nxt_pre;

	// ==========================================================
	// Millisecond prescaler and countdown; zero ms still lasts one cycle
	always_comb begin
		nxt_busy    = busy_ff;
		nxt_ms_left = ms_left_ff;
		nxt_pre     = pre_ff;
		if (start_i) begin
			nxt_busy    = 1'b1;
			nxt_ms_left = ms_i;
			nxt_pre     = PRE_TOP;
		end else if (busy_ff) begin
			if (ms_left_ff == 16'h0000) begin
				nxt_busy = 1'b0;
			end else if (pre_ff == 16'h0000) begin
				nxt_pre     = PRE_TOP;
				nxt_ms_left = ms_left_ff - 16'h0001;
			end else begin
				nxt_pre = pre_ff - 16'h0001;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			busy_ff    <= 1'b0;
			ms_left_ff <= 16'h0000;
			pre_ff     <= 16'h0000;
		end else begin
			busy_ff    <= nxt_busy;
			ms_left_ff <= nxt_ms_left;
			pre_ff     <= nxt_pre;
		end
	end

	assign busy_o = busy_ff;

endmodule : ms_delay_timer

`default_nettype wire

// ===== testbench/ascii_link_read_framer_chk.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Port-level checks of the read framer
module ascii_link_read_framer_chk #(
	parameter int MS_CYCLES = 10000
) (
	input  wire logic       core_clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic [4:0] station_i,
	input  wire logic       rx_valid_i,
	input  wire logic [7:0] tx_data_o,
	input  wire logic       tx_valid_o,
	input  wire logic       tx_ready_i,
	input  wire logic       rd_req_o,
	input  wire logic [7:0] rd_code_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	logic        armed_ff;
	logic        nxt_armed;
	logic [31:0] gap_ff;
	logic [31:0] nxt_gap;
	// Cycles since an accepted read; armed until its reply starts
	always_comb begin
		nxt_armed = rd_req_o | (armed_ff & ~tx_valid_o);
		nxt_gap   = rd_req_o ? 32'h0 : gap_ff + 32'h1;
	end
	always_ff @(posedge core_clk_i) begin
		armed_ff <= sys_rst_i ? 1'b0 : nxt_armed;
		gap_ff   <= sys_rst_i ? 32'h0 : nxt_gap;
	end
	// First reply character taken by the host
	sequence s_reply_head;
		tx_valid_o && tx_ready_i && (tx_data_o == ascii_link_pkg::CH_STX ||
			tx_data_o == ascii_link_pkg::CH_NAK);
	endsequence
	a_req_pulse: assert property (rd_req_o |=> !rd_req_o [*2])
		else $error("read request pulse too long");
	a_code_hold: assert property ($changed(rd_code_o) |-> rd_req_o)
		else $error("code moved without a request");
	a_data_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
		else $error("reply character dropped while stalled");
	a_reply_start: assert property ($rose(tx_valid_o) |->
		tx_data_o == ascii_link_pkg::CH_STX || tx_data_o == ascii_link_pkg::CH_NAK)
		else $error("reply opens with a wrong control character");
	a_station_echo: assert property (s_reply_head |=> tx_valid_o &&
		tx_data_o == {7'h18, station_i[4]})
		else $error("station high character wrong");
	a_req_after_rx: assert property (rd_req_o |-> $past(rx_valid_i, 2) || $past(rx_valid_i, 3))
		else $error("request accepted without a closing character");
	a_quiet_wait: assert property (rd_req_o |=> !tx_valid_o [*8])
		else $error("reply began inside the waiting time");
	// Limitation: only the shortest check time is bounded, the code picks the rest
	a_check_time: assert property ($rose(tx_valid_o) && armed_ff |-> gap_ff >= 10 * MS_CYCLES - 2)
		else $error("reply skipped the data check time");
endmodule : ascii_link_read_framer_chk
bind ascii_link_read_framer ascii_link_read_framer_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (
	.core_clk_i, .sys_rst_i, .station_i, .rx_valid_i, .tx_data_o, .tx_valid_o,
	.tx_ready_i, .rd_req_o, .rd_code_o
);
`default_nettype wire

// ===== testbench/host_link_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Host computer: sends characters, takes reply characters with random stalls
module host_link_model (
	input  wire logic                 core_clk_i,
	input  wire logic [7:0]           tx_data_i,
	input  wire logic                 tx_valid_i,
	output logic                      tx_ready_o,
	output ascii_link_pkg::rx_char_t  rx_char_o,
	output logic                      rx_valid_o
);
	logic [7:0] got_q[$];
	initial begin
		tx_ready_o = 1'b0;
		rx_valid_o = 1'b0;
		rx_char_o  = '0;
	end
	// A slow host must never lose or repeat a reply character
	always @(posedge core_clk_i) begin
		if (tx_valid_i && tx_ready_o)
			got_q.push_back(tx_data_i);
		tx_ready_o <= ($urandom_range(3) != 0);
	end
	// One character with link flags {parity, framing, overrun}
	task automatic send_char(input logic [7:0] b, input logic [2:0] fl);
		@(posedge core_clk_i);
		rx_char_o  <= {b, fl};
		rx_valid_o <= 1'b1;
		@(posedge core_clk_i);
		rx_valid_o <= 1'b0;
		rx_char_o  <= {~b, 3'h0}; // Released line shows no stale character
	endtask : send_char
endmodule : host_link_model
`default_nettype wire

// ===== testbench/tb_ascii_link_read_framer.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
	$display("ERROR %0t ns: got %h want %h", $time, (a), (b)); end end
// ==========================================
// Self-checking bench for the read framer
module tb_ascii_link_read_framer;
	localparam int MS = 4; // Short millisecond keeps waits to a few hundred cycles
	logic                      core_clk_i, sys_rst_i, rx_valid, tx_valid, tx_ready;
	logic                      rd_req, rsp_valid, tx_prev;
	logic [4:0]                own;
	logic [15:0]               wait_set;
	logic [1:0]                le;
	logic [7:0]                tx_data, rd_code, code, rsp_cnt;
	ascii_link_pkg::rx_char_t  rx_char;
	ascii_link_pkg::read_rsp_t rsp;
	int                        n_fail, cmp_count, n_req, cyc, t_req, t_tx, nreq0, w;
	logic [7:0]                exp_q[$];
	logic [3:0]                dg;
	ascii_link_read_framer #(.MS_CYCLES(MS)) DUT (.core_clk_i, .sys_rst_i, .station_i(own),
		.reply_wait_setting_i(wait_set), .line_end_selection_i(le), .rx_char_i(rx_char),
		.rx_valid_i(rx_valid), .tx_data_o(tx_data), .tx_valid_o(tx_valid),
		.tx_ready_i(tx_ready), .rd_req_o(rd_req), .rd_code_o(rd_code),
		.rd_rsp_valid_i(rsp_valid), .rd_rsp_i(rsp));
	host_link_model HOST (.core_clk_i, .tx_data_i(tx_data), .tx_valid_i(tx_valid),
		.tx_ready_o(tx_ready), .rx_char_o(rx_char), .rx_valid_o(rx_valid));
	initial begin
		core_clk_i = 1'b0;
		forever #50 core_clk_i = ~core_clk_i;
	end
	// Read data source answers each request after a random delay; also times replies
	always @(posedge core_clk_i) begin
		cyc       <= cyc + 1;
		tx_prev   <= tx_valid;
		rsp_valid <= 1'b0;
		if (tx_valid && !tx_prev)
			t_tx <= cyc;
		if (rd_req) begin
			n_req   <= n_req + 1;
			t_req   <= cyc;
			rsp_cnt <= 8'h1 + 8'($urandom_range(60));
		end else if (rsp_cnt == 8'h1) begin
			rsp_valid <= 1'b1;
			rsp_cnt   <= 8'h0;
		end else if (rsp_cnt != 8'h0)
			rsp_cnt <= rsp_cnt - 8'h1;
	end
	function automatic logic [7:0] hx(input logic [3:0] n);
		return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
	endfunction : hx
	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	task automatic le_send(input logic [1:0] sel);
		if (sel[0]) HOST.send_char(ascii_link_pkg::CH_CR, 3'h0);
		if (sel[1]) HOST.send_char(ascii_link_pkg::CH_LF, 3'h0);
	endtask : le_send
	// kind: 0 good, 1..3 link flag, 4 bad char, 5 bad sum, 6 wrong line end
	task automatic send_req(input logic [7:0] stn, input int kind);
		logic [7:0] q[$];
		logic [7:0] s;
		q = {hx(stn[7:4]), hx(stn[3:0]), hx(code[7:4]), hx(code[3:0])};
		if (wait_set == ascii_link_pkg::WAIT_DIGIT_MODE) q.push_back(hx(dg));
		if (kind == 4) q[2] = 8'h47;
		s = 8'h0;
		foreach (q[k]) s += q[k];
		if (kind == 5) s = ~s;
		q.push_back(hx(s[7:4]));
		q.push_back(hx(s[3:0]));
		HOST.send_char(8'h41 + 8'($urandom_range(5)), 3'h0);
		HOST.send_char(ascii_link_pkg::CH_ENQ, 3'h0);
		foreach (q[k]) HOST.send_char(q[k], (k == 3 && kind inside {[1:3]}) ? 3'h4 >> (kind - 1) : 3'h0);
		if (kind == 6) le_send(2'h2);
		else le_send(le);
	endtask : send_req
	task automatic answer(input logic [7:0] c);
		repeat (10 * MS) @(posedge core_clk_i);
		HOST.send_char(c, 3'h0);
		HOST.send_char(hx({3'h0, own[4]}), 3'h0);
		HOST.send_char(hx(own[3:0]), 3'h0);
		le_send(le);
	endtask : answer
	task automatic exp_tail();
		if (le[0]) exp_q.push_back(ascii_link_pkg::CH_CR);
		if (le[1]) exp_q.push_back(ascii_link_pkg::CH_LF);
	endtask : exp_tail
	task automatic exp_read(input int n);
		logic [7:0] s;
		exp_q = {ascii_link_pkg::CH_STX, hx({3'h0, own[4]}), hx(own[3:0])};
		for (int j = 0; j < n; j++) exp_q.push_back(rsp.data[j]);
		exp_q.push_back(ascii_link_pkg::CH_ETX);
		s = 8'h0;
		foreach (exp_q[k]) if (k > 0) s += exp_q[k];
		exp_q.push_back(hx(s[7:4]));
		exp_q.push_back(hx(s[3:0]));
		exp_tail();
	endtask : exp_read
	task automatic chk_reply();
		w = 0;
		while (HOST.got_q.size() < exp_q.size() && w < 3000) begin
			@(posedge core_clk_i);
			w++;
		end
		repeat (4) @(posedge core_clk_i);
		`CHK(HOST.got_q.size(), exp_q.size())
		foreach (exp_q[k]) if (k < HOST.got_q.size()) `CHK(HOST.got_q[k], exp_q[k])
		HOST.got_q.delete();
		if (w == 3000) begin
			n_fail++;
			report_and_stop();
		end
	endtask : chk_reply
	initial begin
		logic [3:0] errs[7];
		int         lens[4];
		errs = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h7, 4'h2, 4'h3};
		lens = '{4, 2, 6, 20};
		void'($urandom(7));
		{sys_rst_i, own, wait_set, le, code, dg, rsp} = '0;
		sys_rst_i = 1'b1;
		{n_fail, cmp_count, n_req, cyc, t_req, t_tx} = '0;
		{rsp_cnt, tx_prev} = '0;
		repeat (10) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		// Reads in all formats and line ends; digit and setting waits alternate
		for (int i = 0; i < 8; i++) begin
			own      <= (i == 0) ? 5'h1f : 5'($urandom_range(31));
			le       <= 2'(i);
			wait_set <= i[0] ? 16'($urandom_range(5)) : ascii_link_pkg::WAIT_DIGIT_MODE;
			code     <= 8'($urandom);
			dg       <= (i == 2) ? 4'hf : 4'($urandom_range(15));
			rsp.fmt  <= ascii_link_pkg::read_fmt_t'(i % 4);
			for (int j = 0; j < 20; j++) rsp.data[j] <= hx(4'($urandom));
			rsp.is_err   <= (i == 5); // The read source refuses one read
			rsp.err_code <= (i == 5) ? ascii_link_pkg::ERR_CHAR : ascii_link_pkg::ERR_NONE;
			nreq0 = n_req;
			@(posedge core_clk_i);
			send_req({3'h0, own}, 0);
			exp_read(lens[i % 4]);
			if (i == 5) begin
				exp_q = {ascii_link_pkg::CH_NAK, hx({3'h0, own[4]}), hx(own[3:0]),
					hx(ascii_link_pkg::ERR_CHAR)};
				exp_tail();
			end
			chk_reply();
			`CHK(n_req, nreq0 + 1)
			`CHK(rd_code, code)
			w = (i[0] ? int'(wait_set) : 10 * int'(dg)) * MS;
			`CHK(t_tx - t_req >= w + 10 * MS - 2, 1'b1)
			`CHK(t_tx - t_req <= w + 30 * MS + 80, 1'b1)
			if (i[1]) begin
				answer(ascii_link_pkg::CH_NAK);
				chk_reply();
			end
			answer(ascii_link_pkg::CH_ACK);
			$display("read test %0d done", i);
		end
		// Each request fault gets a negative reply with its code
		le       <= 2'h1;
		wait_set <= ascii_link_pkg::WAIT_DIGIT_MODE;
		nreq0 = n_req;
		@(posedge core_clk_i); // New wait mode must settle before a frame is built
		for (int k = 1; k <= 6; k++) begin
			send_req({3'h0, own}, k);
			exp_q = {ascii_link_pkg::CH_NAK, hx({3'h0, own[4]}), hx(own[3:0]), hx(errs[k])};
			exp_tail();
			chk_reply();
			`CHK(n_req, nreq0)
			$display("error test %0d done", k);
		end
		// Foreign station and out-of-range field stay silent
		send_req({3'h0, own + 5'h1}, 0);
		send_req(8'h20, 0);
		repeat (800) @(posedge core_clk_i);
		`CHK(HOST.got_q.size(), 0)
		`CHK(n_req, nreq0)
		$display("station test done");
		report_and_stop();
	end
	initial begin
		repeat (100000) @(posedge core_clk_i);
		n_fail++;
		report_and_stop();
	end
endmodule : tb_ascii_link_read_framer
`default_nettype wire
